/* hw/pwm_flt_pkg.sv */
package pwm_flt_pkg;
  // ==========================================
  // Register byte offsets on APB
  localparam logic [11:0] OFS_OUTCTL = 12'h000;   // Output control register
  localparam logic [11:0] OFS_FLTLIM = 12'h004;   // Fault and current-limit register
  localparam logic [11:0] OFS_TRIG   = 12'h008;   // Primary trigger register
  localparam logic [11:0] OFS_STRIG  = 12'h00C;   // Secondary trigger register
  localparam logic [11:0] OFS_STATUS = 12'h010;   // Override enable and pin status
  // ==========================================
  // Output control field positions
  localparam int OC_OVERRIDE_SYNC_SELECT   = 0;                  // Override sync select
  localparam int OC_SWAP    = 1;                  // Swap high and low
  localparam int OC_CLDLO   = 2;                  // Limit override state, low
  localparam int OC_CLDHI   = 3;                  // Limit override state, high
  localparam int OC_OVDLO   = 6;                  // Software override state, low
  localparam int OC_OVDHI   = 7;                  // Software override state, high
  localparam int OC_OVENL   = 8;                  // Software override enable, low
  localparam int OC_OVENH   = 9;                  // Software override enable, high
  localparam int OC_POLL    = 12;                 // Low output polarity (1 = active low)
  localparam int OC_HIGH_OUTPUT_POLARITY    = 13;                 // High output polarity (1 = active low)
  localparam int OC_FLDLO   = 4;                  // Fault override state, low
  localparam int OC_FLDHI   = 5;                  // Fault override state, high
  localparam logic [15:0] OC_MASK = 16'h33FF;     // Implemented bits
  // ==========================================
  // Fault-limit field positions
  localparam int FL_FMOD0   = 0;                  // Fault mode select low bit
  localparam int FL_FPOL    = 2;                  // Fault polarity
  localparam int FL_FSRC    = 3;                  // Fault source select, 5 bits
  localparam int FL_LIMIT_ENABLE   = 8;                  // Limit enable
  localparam int FL_LIMIT_POLARITY   = 9;                  // Limit polarity
  localparam int FL_LIMIT_SOURCE_SELECT   = 10;                 // Limit source select, 5 bits
  localparam int FL_IFLT    = 15;                 // Independent fault mode
  // ==========================================
  // Reset values and trigger layout
  localparam logic [15:0] RST_REG   = 16'h0000;   // All registers reset to zero
  localparam logic [15:0] TRIG_MASK = 16'hFFF8;   // Bits 2-0 read as zero
  localparam int          TRIG_LSB  = 3;          // Compare value starts here
  // ==========================================
  // Grouped pin-side signals
  typedef struct packed {
    logic high;                                   // High side pin level
    logic low;                                    // Low side pin level
  } pin_pair_t;
endpackage

/* hw/fault_select.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Source selector with polarity
module fault_select
(
  // Inputs
  input  wire logic [7:0] faultIn,                 // Eight fault inputs, raw levels
  input  wire logic [4:0] srcSel,                  // Source select
  input  wire logic       activeLow,               // 1 = source active low
  // Result
  output logic            active                   // Selected source asserted
);
  // Reserved codes select nothing
  always_comb
  begin
    if (srcSel < 5'h08)
      active = faultIn[srcSel[2:0]] ^ activeLow;
    else
      active = 1'b0;
  end
endmodule
`default_nettype wire

/* hw/pwm_fault_limit_override_trigger.sv */
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Normal mode limit forces pins from limit state unless a fault is in force
// - Independent mode ignores limit override state
// - Override states pass through output polarity
// - Swap routes high to low and back
// - Override sync picks time base or clock
// - Primary compare in bits 15-3 triggers converter
module pwm_fault_limit_override_trigger
(
  // Clock and reset
  input  wire logic        core_clk,               // 50 MHz clock
  input  wire logic        rst_n,                  // Async reset, active low
  input  wire logic        clkEn,                  // Freezes all state when low
  // APB slave
  input  wire logic        psel,                   // Select
  input  wire logic        penable,                // Access phase
  input  wire logic        pwrite,                 // Write
  input  wire logic [11:0] paddr,                  // Byte address
  input  wire logic [31:0] pwdata,                 // Write data
  output logic      [31:0] prdata,                 // Read data
  output logic             pready,                 // Ready
  output logic             pslverr,                // Error on unmapped address
  // PWM generator side
  input  wire logic        genHigh,                // Raw high generator signal
  input  wire logic        genLow,                 // Raw low generator signal
  input  wire logic        timeBaseSync,           // Time base period boundary pulse
  input  wire logic [12:0] localTimeBase,          // Primary local time base
  input  wire logic [12:0] secTimeBase,            // Secondary local time base
  input  wire logic        localMode,              // Primary runs on local time base
  input  wire logic        secLocalMode,           // Secondary runs on local time base
  input  wire logic [7:0]  faultIn,                // Fault inputs 1 to 8
  // Outputs
  output logic             highSideOutput,         // High pin
  output logic             lowSideOutput,          // Low pin
  output logic             adcTrigger,             // Primary converter trigger pulse
  output logic             adcTriggerSec           // Secondary converter trigger pulse
);
  // ==========================================
  // State record
  typedef struct packed {
    logic [15:0] outCtl;                           // Output control register
    logic [15:0] fltLim;                           // Fault-limit register
    logic [15:0] trig;                             // Primary trigger register
    logic [15:0] strig;                            // Secondary trigger register
    logic [1:0]  ovrActive;                        // Applied override enables, H/L
    logic [1:0]  ovrState;                         // Applied override states, H/L
    logic [31:0] rdata;                            // Read data
    logic        ready;                            // APB ready
    logic        err;                              // APB error
    pwm_flt_pkg::pin_pair_t pins;                  // Registered pins
    logic        trg;                              // Primary trigger
    logic        trgSec;                           // Secondary trigger
  } state_t;

  state_t st_r;                                    // Current state
  state_t st_nxt;                                  // Next state
  logic   limitHit;                                // Selected limit source active
  logic   faultHit;                                // Selected fault source active

  // ==========================================
  // Source selectors
  fault_select u_limSel
  (
    .faultIn   (faultIn),
    .srcSel    (st_r.fltLim[pwm_flt_pkg::FL_LIMIT_SOURCE_SELECT +: 5]),
    .activeLow (st_r.fltLim[pwm_flt_pkg::FL_LIMIT_POLARITY]),
    .active    (limitHit)
  );

  fault_select u_fltSel
  (
    .faultIn   (faultIn),
    .srcSel    (st_r.fltLim[pwm_flt_pkg::FL_FSRC +: 5]),
    .activeLow (st_r.fltLim[pwm_flt_pkg::FL_FPOL]),
    .active    (faultHit)
  );

  // ==========================================
  // Read decode
  function automatic logic [15:0] readReg(input state_t s, input logic [11:0] a);
    case (a)
      pwm_flt_pkg::OFS_OUTCTL: readReg = s.outCtl;
      pwm_flt_pkg::OFS_FLTLIM: readReg = s.fltLim;
      pwm_flt_pkg::OFS_TRIG:   readReg = s.trig;
      pwm_flt_pkg::OFS_STRIG:  readReg = s.strig;
      pwm_flt_pkg::OFS_STATUS: readReg = {12'h000, s.ovrActive, s.pins.high, s.pins.low};
      default:                 readReg = 16'h0000;
    endcase
  endfunction

  // Address is mapped
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == pwm_flt_pkg::OFS_OUTCTL) || (a == pwm_flt_pkg::OFS_FLTLIM) ||
               (a == pwm_flt_pkg::OFS_TRIG) || (a == pwm_flt_pkg::OFS_STRIG) ||
               (a == pwm_flt_pkg::OFS_STATUS);
  endfunction

  // ==========================================
  // Next-state logic
  always_comb
  begin
    logic       indep;                             // Independent fault mode
    logic       limOn;                             // Limit event in force
    logic       fltOn;                             // Fault event in force
    logic       actH;                              // High active/inactive level
    logic       actL;                              // Low active/inactive level
    logic       swH;                               // Generator signal to high pin
    logic       swL;                               // Generator signal to low pin
    logic [1:0] fltData;                           // Fault override state
    logic [1:0] limData;                           // Limit override state
    indep   = 1'b0;
    limOn   = 1'b0;
    fltOn   = 1'b0;
    actH    = 1'b0;
    actL    = 1'b0;
    swH     = 1'b0;
    swL     = 1'b0;
    fltData = 2'b00;
    limData = 2'b00;
    st_nxt  = st_r;
    // APB: one wait-free access phase, ready pulses once
    st_nxt.ready = 1'b0;
    st_nxt.err   = 1'b0;
    if (psel && !penable)
    begin
      st_nxt.ready = 1'b1;
      st_nxt.err   = !isMapped(paddr);
      st_nxt.rdata = {16'h0000, readReg(st_r, paddr)};
    end
    if (psel && penable && st_r.ready && pwrite)
    begin
      case (paddr)
        pwm_flt_pkg::OFS_OUTCTL: st_nxt.outCtl = pwdata[15:0] & pwm_flt_pkg::OC_MASK;
        pwm_flt_pkg::OFS_FLTLIM: st_nxt.fltLim = pwdata[15:0];
        pwm_flt_pkg::OFS_TRIG:   st_nxt.trig   = pwdata[15:0] & pwm_flt_pkg::TRIG_MASK;
        pwm_flt_pkg::OFS_STRIG:  st_nxt.strig  = pwdata[15:0] & pwm_flt_pkg::TRIG_MASK;
        default:                 st_nxt.outCtl = st_r.outCtl;
      endcase
    end
    // Software override applied at clock or time base boundary
    if (!st_r.outCtl[pwm_flt_pkg::OC_OVERRIDE_SYNC_SELECT] || timeBaseSync)
    begin
      st_nxt.ovrActive = {st_r.outCtl[pwm_flt_pkg::OC_OVENH], st_r.outCtl[pwm_flt_pkg::OC_OVENL]};
      st_nxt.ovrState  = {st_r.outCtl[pwm_flt_pkg::OC_OVDHI], st_r.outCtl[pwm_flt_pkg::OC_OVDLO]};
    end
    // Swap generator signals
    swH = st_r.outCtl[pwm_flt_pkg::OC_SWAP] ? genLow : genHigh;
    swL = st_r.outCtl[pwm_flt_pkg::OC_SWAP] ? genHigh : genLow;
    actH = swH;
    actL = swL;
    // Software override
    if (st_r.ovrActive[1])
      actH = st_r.ovrState[1];
    if (st_r.ovrActive[0])
      actL = st_r.ovrState[0];
    // Fault and limit overrides
    indep   = st_r.fltLim[pwm_flt_pkg::FL_IFLT];
    limOn   = st_r.fltLim[pwm_flt_pkg::FL_LIMIT_ENABLE] && limitHit;
    fltOn   = (st_r.fltLim[pwm_flt_pkg::FL_FMOD0 +: 2] != 2'b11) && faultHit;
    fltData = {st_r.outCtl[pwm_flt_pkg::OC_FLDHI], st_r.outCtl[pwm_flt_pkg::OC_FLDLO]};
    limData = {st_r.outCtl[pwm_flt_pkg::OC_CLDHI], st_r.outCtl[pwm_flt_pkg::OC_CLDLO]};
    if (indep)
    begin
      // Limit drives high from fault state, fault drives low; limit state unused
      if (limOn)
        actH = fltData[1];
      if (fltOn)
        actL = fltData[0];
    end
    else if (fltOn)
    begin
      actH = fltData[1];
      actL = fltData[0];
    end
    else if (limOn)
    begin
      actH = limData[1];
      actL = limData[0];
    end
    // Polarity sets final pin level
    st_nxt.pins.high = actH ^ st_r.outCtl[pwm_flt_pkg::OC_HIGH_OUTPUT_POLARITY];
    st_nxt.pins.low  = actL ^ st_r.outCtl[pwm_flt_pkg::OC_POLL];
    // Converter triggers on compare match
    st_nxt.trg    = localMode && (localTimeBase == st_r.trig[15:pwm_flt_pkg::TRIG_LSB]);
    st_nxt.trgSec = secLocalMode && (secTimeBase == st_r.strig[15:pwm_flt_pkg::TRIG_LSB]);
  end

  // ==========================================
  // State register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (clkEn)
      st_r <= st_nxt;
  end

  // ==========================================
  // Outputs
  assign prdata         = st_r.rdata;
  assign pready         = st_r.ready;
  assign pslverr        = st_r.err;
  assign highSideOutput = st_r.pins.high;
  assign lowSideOutput  = st_r.pins.low;
  assign adcTrigger     = st_r.trg;
  assign adcTriggerSec  = st_r.trgSec;

  // ==========================================
  // Checks
  property p_limHigh;
    @(posedge core_clk) disable iff (!rst_n)
    (clkEn && !st_r.fltLim[15] && st_r.fltLim[8] && limitHit && !faultHit) |=>
      (highSideOutput == ($past(st_r.outCtl[3]) ^ $past(st_r.outCtl[13])));
  endproperty
  a_limHigh: assert property (p_limHigh) else $error("limit high state wrong");

  property p_trigLow;
    @(posedge core_clk) disable iff (!rst_n)
    st_r.trig[2:0] == 3'h0 && st_r.strig[2:0] == 3'h0;
  endproperty
  a_trigLow: assert property (p_trigLow) else $error("trigger low bits set");

  property p_swap;
    @(posedge core_clk) disable iff (!rst_n)
    (clkEn && st_r.outCtl[15:0] == 16'h0002 && st_r.fltLim == 16'h0003 && st_r.ovrActive == 2'b00) |=>
      (highSideOutput == $past(genLow)) && (lowSideOutput == $past(genHigh));
  endproperty
  a_swap: assert property (p_swap) else $error("swap routing wrong");

  property p_trig;
    @(posedge core_clk) disable iff (!rst_n)
    (clkEn && localMode && localTimeBase == st_r.trig[15:3]) |=> adcTrigger;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger missed");

  property p_trigSec;
    @(posedge core_clk) disable iff (!rst_n)
    (clkEn && secLocalMode && secTimeBase == st_r.strig[15:3]) |=> adcTriggerSec;
  endproperty
  a_trigSec: assert property (p_trigSec) else $error("secondary trigger missed");

  property p_noTrig;
    @(posedge core_clk) disable iff (!rst_n)
    (clkEn && !localMode) |=> !adcTrigger;
  endproperty
  a_noTrig: assert property (p_noTrig) else $error("trigger outside local time base");
endmodule
`default_nettype wire

/* test/switch_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Half-bridge power stage on the two pins
module switch_model
(
  // Gate drives
  input  wire logic gateHigh,   // Upper switch on when high
  input  wire logic gateLow,    // Lower switch on when high
  // Bridge node
  output var  logic nodeLevel   // Switched node level
);
  // Node follows the upper switch unless the lower one conducts
  always_comb nodeLevel = gateHigh & ~gateLow;
endmodule
`default_nettype wire

/* test/tb_pwm_fault_limit_override_trigger.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_fault_limit_override_trigger;
  // ==========================================
  // Signals
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;  // Clock, reset, APB
  logic [11:0] paddr;                                                        // APB address
  logic [31:0] pwdata, prdata, rd;                                           // APB data
  logic        genHigh, genLow, timeBaseSync, localMode, secLocalMode;       // Generator side
  logic [12:0] localTimeBase, secTimeBase, v;                                // Time bases
  logic [7:0]  faultIn;                                                      // Fault inputs
  logic        highSideOutput, lowSideOutput, adcTrigger, adcTriggerSec;     // Outputs
  logic        nodeLevel;                                                    // Bridge node
  logic [15:0] oc, fl;                                                       // Shadow registers
  int          errors, tests_run, cyc;                                       // Counters
  // ==========================================
  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  pwm_fault_limit_override_trigger DUT (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .genHigh(genHigh), .genLow(genLow), .timeBaseSync(timeBaseSync),
    .localTimeBase(localTimeBase), .secTimeBase(secTimeBase), .localMode(localMode),
    .secLocalMode(secLocalMode), .faultIn(faultIn), .highSideOutput(highSideOutput),
    .lowSideOutput(lowSideOutput), .adcTrigger(adcTrigger), .adcTriggerSec(adcTriggerSec));
  switch_model PART (.gateHigh(highSideOutput), .gateLow(lowSideOutput), .nodeLevel(nodeLevel));
  // ==========================================
  // Checking and reporting
  task automatic stop_test;
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string what);
    errors++;
    $display("Error at %0t: %s mismatch", $time, what);
  endtask
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) fail("register");
  endtask
  task automatic chkPin(input logic [1:0] exp);
    tests_run++;
    if ({highSideOutput, lowSideOutput} !== exp) fail("pin");
    if (nodeLevel !== (exp[1] & ~exp[0])) fail("bridge node");
  endtask
  task automatic chkTrig(input logic [1:0] exp);
    tests_run++;
    if ({adcTrigger, adcTriggerSec} !== exp) fail("trigger");
  endtask
  // Timeout guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      stop_test();
    end
  end
  // ==========================================
  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Reference model of the pin pair
  function automatic logic [1:0] model(input logic gh, input logic gl);
    logic h, l, fa, la;
    h = oc[1] ? gl : gh;
    l = oc[1] ? gh : gl;
    if (oc[9]) h = oc[7];
    if (oc[8]) l = oc[6];
    fa = fl[1:0] != 2'b11 && fl[7:3] < 8 && (faultIn[fl[5:3]] ^ fl[2]);
    la = fl[8] && fl[14:10] < 8 && (faultIn[fl[12:10]] ^ fl[9]);
    if (fl[15])
    begin
      if (la) h = oc[5];
      if (fa) l = oc[4];
    end
    else if (fa) {h, l} = oc[5:4];
    else if (la) {h, l} = oc[3:2];
    return {h ^ oc[13], l ^ oc[12]};
  endfunction
  // Configure, then apply random generator and fault levels
  task automatic pins(input logic [15:0] o, input logic [15:0] f, input logic [7:0] fi);
    oc = o;
    fl = f;
    apb(1'b1, pwm_flt_pkg::OFS_OUTCTL, {16'h0000, o});
    apb(1'b1, pwm_flt_pkg::OFS_FLTLIM, {16'h0000, f});
    repeat (4)
    begin
      faultIn <= fi;
      genHigh <= 1'($urandom);
      genLow <= 1'($urandom);
      @(posedge core_clk);
      @(negedge core_clk);
      chkPin(model(genHigh, genLow));
      fi = 8'($urandom);
      @(posedge core_clk);
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    genHigh = 1'b0; genLow = 1'b0; timeBaseSync = 1'b0; localMode = 1'b0; secLocalMode = 1'b0;
    localTimeBase = 13'h0; secTimeBase = 13'h0; faultIn = 8'h00; errors = 0; tests_run = 0; cyc = 0;
    rd = $urandom(19593);
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, then implemented bits of each writable register
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chkReg({15'h0, er, rd[15:0]}, 32'h0);
      apb(1'b1, 12'(4 * i), 32'hFFFFFFFF);
      apb(1'b0, 12'(4 * i), 32'h0);
      chkReg(rd, (i == 0) ? 32'h33FF : (i == 1) ? 32'hFFFF : 32'hFFF8);
    end
    // Refused writes: status and unmapped
    apb(1'b1, pwm_flt_pkg::OFS_STATUS, 32'h0);
    chkReg({31'h0, er}, 32'h0);
    apb(1'b1, 12'h014, 32'h0);
    chkReg({31'h0, er}, 32'h1);
    // Swap, polarity and immediate software override
    pins(16'h0002, 16'h0003, 8'hFF);
    repeat (8) pins(16'($urandom) & 16'h33C2, 16'h0003, 8'h00);
    // Limit and fault in normal and independent modes over all sources
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 8; s++)
        pins(16'($urandom) & 16'h303C, {1'(m), 5'(7 - s), 1'($urandom), 1'b1, 5'(s), 3'($urandom)},
             8'($urandom));
    // Override held until the time base boundary
    oc = 16'h0000;
    fl = 16'h0003;
    genHigh <= 1'b0;
    genLow <= 1'b0;
    apb(1'b1, pwm_flt_pkg::OFS_FLTLIM, 32'h0003);
    apb(1'b1, pwm_flt_pkg::OFS_OUTCTL, 32'h0001);
    apb(1'b1, pwm_flt_pkg::OFS_OUTCTL, 32'h0281);
    repeat (3) @(posedge core_clk);
    chkPin(2'b00);
    timeBaseSync <= 1'b1;
    @(posedge core_clk);
    timeBaseSync <= 1'b0;
    repeat (2) @(posedge core_clk);
    chkPin(2'b10);
    // Converter triggers on primary and secondary compare
    for (int k = 0; k < 4; k++)
    begin
      v = 13'($urandom);
      apb(1'b1, pwm_flt_pkg::OFS_TRIG, {16'h0, v, 3'b111});
      apb(1'b1, pwm_flt_pkg::OFS_STRIG, {16'h0, v ^ 13'h1, 3'b000});
      localMode <= k[1];
      secLocalMode <= k[0];
      localTimeBase <= v;
      secTimeBase <= v ^ 13'h1;
      @(posedge core_clk);
      @(negedge core_clk);
      chkTrig({k[1], k[0]});
      @(posedge core_clk);
      localTimeBase <= v + 13'h1;
      secTimeBase <= v;
      @(posedge core_clk);
      @(negedge core_clk);
      chkTrig(2'b00);
      @(posedge core_clk);
    end
    stop_test();
  end
endmodule
`default_nettype wire
